// ===== logic/line_status_ident.sv
/*
 * Line status and interrupt identity logic of one serial channel: receive
 * ready and error flags, per-character error tags for FIFO mode, break
 * detection, transmit emptiness, and the ranked interrupt identity.
 * Assumes the receive and transmit datapaths run on core_clk and report
 * their events as one-cycle pulses; serial_input is an asynchronous pin.
 */
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "line_status_regs.svh"

module line_status_ident
    import line_status_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r,
    // mode and interrupt enables
    input wire logic fifo_enable_bit,
    input wire logic en_rx_data,
    input wire logic en_txe,
    input wire logic en_line,
    input wire logic en_modem,
    // receive side
    input wire logic serial_input,
    input wire logic baud16_en,
    input wire logic [3:0] char_bits,
    input wire logic rx_char_done,
    input wire logic rx_parity_bad,
    input wire logic rx_frame_bad,
    input wire logic rx_data_read,
    input wire logic rx_trigger_reached,
    input wire logic rx_timeout,
    output logic rx_push_r,
    output logic rx_hold_off_r,
    output logic rx_resync_r,
    // transmit side and modem
    input wire logic tx_holding_write,
    input wire logic tx_shift_load,
    input wire logic tx_shift_busy,
    input wire logic modem_change,
    // interrupt request
    output logic irq_r
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic ls_rd;
    logic id_rd;
    // writes to either address are ignored; host keeps them read only
    assign ls_rd = reg_rd && (reg_addr == `LS_ADDR);
    assign id_rd = reg_rd && (reg_addr == `ID_ADDR);

    // ****************************************************************
    // break detection on the serial pin
    // ****************************************************************
    logic ser_meta_r;
    logic ser_r;
    brk_state_type brk_state_r;
    logic [7:0] low_cnt_r;
    logic [7:0] char_ticks;
    logic brk_evt;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ser_meta_r <= 1'b1;
            ser_r <= 1'b1;
        end else begin
            ser_meta_r <= serial_input;
            ser_r <= ser_meta_r;
        end
    end

    assign char_ticks = {char_bits, 4'h0};
    // strictly longer than a character: one tick past the full count
    assign brk_evt = (brk_state_r == BRK_COUNT) && !ser_r && baud16_en
        && (low_cnt_r == char_ticks);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            brk_state_r <= BRK_IDLE;
            low_cnt_r <= 8'h00;
        end else begin
            unique case (brk_state_r)
                BRK_IDLE: begin
                    low_cnt_r <= 8'h00;
                    if (!ser_r) begin
                        brk_state_r <= BRK_COUNT;
                    end
                end
                BRK_COUNT: begin
                    if (ser_r) begin
                        brk_state_r <= BRK_IDLE;
                    end else if (brk_evt) begin
                        brk_state_r <= BRK_HELD;
                    end else if (baud16_en) begin
                        low_cnt_r <= low_cnt_r + 8'h01;
                    end
                end
                BRK_HELD: begin
                    // released by line high; receiver then hunts a start
                    if (ser_r) begin
                        brk_state_r <= BRK_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // receive accounting and error tags
    // ****************************************************************
    logic acc;
    err_tag_type acc_tag;
    logic [4:0] rx_cap;
    logic [4:0] rx_count_r;
    logic rx_full;
    logic push_ok;
    logic overrun;
    logic pop;
    logic [3:0] wr_ptr_r;
    logic [3:0] rd_ptr_r;
    err_tag_type err_tags_r [16];
    logic [15:0] err_live;
    logic any_err;
    logic head_seen_r;

    // chars arriving while the break is held are dropped
    assign acc = (rx_char_done && (brk_state_r != BRK_HELD))
        || brk_evt;
    assign acc_tag = brk_evt ? 3'b100 : {1'b0, rx_frame_bad, rx_parity_bad};
    assign rx_cap = fifo_enable_bit ? `RX_DEPTH : `CHAR_DEPTH;
    assign rx_full = (rx_count_r == rx_cap);
    assign push_ok = acc && !rx_full;
    assign overrun = acc && rx_full;
    assign pop = rx_data_read && (rx_count_r != 5'h00);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_count_r <= 5'h00;
            wr_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
        end else begin
            // ready follows the count: set on push, clear when drained
            rx_count_r <= rx_count_r + {4'h0, push_ok}
                - {4'h0, pop};
            if (push_ok) begin
                wr_ptr_r <= wr_ptr_r + 4'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 4'h1;
            end
        end
    end

    generate
        for (genvar i = 0; i < 16; i++) begin : g_tag
            logic [3:0] offs;
            assign offs = 4'(i) - rd_ptr_r;
            // the head is the entry being reported, not a later one
            assign err_live[i] = ({1'b0, offs} < rx_count_r)
                && (offs != 4'h0) && (err_tags_r[i] != 3'b000);
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    err_tags_r[i] <= 3'b000;
                end else if (push_ok && (wr_ptr_r == 4'(i))) begin
                    err_tags_r[i] <= acc_tag;
                end
            end
        end
    endgenerate

    assign any_err = |err_live;

    // head tag shows until a status read; a pop brings a fresh head
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            head_seen_r <= 1'b0;
        end else if (pop) begin
            head_seen_r <= 1'b0;
        end else if (ls_rd) begin
            head_seen_r <= 1'b1;
        end
    end

    // ****************************************************************
    // line status flags
    // ****************************************************************
    logic oe_r;
    logic par_r;
    logic frm_r;
    logic brk_r;
    logic sum_r;
    err_tag_type head_tag;
    logic par_d;
    logic frm_d;
    logic brk_d;
    logic chr_acc;

    assign chr_acc = acc && !fifo_enable_bit;
    assign head_tag = ((rx_count_r != 5'h00) && !head_seen_r)
        ? err_tags_r[rd_ptr_r] : 3'b000;
    assign par_d = fifo_enable_bit ? head_tag[`TAG_PAR] : par_r;
    assign frm_d = fifo_enable_bit ? head_tag[`TAG_FRM] : frm_r;
    assign brk_d = fifo_enable_bit ? head_tag[`TAG_BRK] : brk_r;

    // a new event in the read cycle survives the clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            oe_r <= 1'b0;
            par_r <= 1'b0;
            frm_r <= 1'b0;
            brk_r <= 1'b0;
        end else begin
            oe_r <= overrun || (oe_r && !ls_rd);
            par_r <= (chr_acc && acc_tag[`TAG_PAR])
                || (par_r && !ls_rd);
            frm_r <= (chr_acc && acc_tag[`TAG_FRM])
                || (frm_r && !ls_rd);
            brk_r <= (chr_acc && acc_tag[`TAG_BRK])
                || (brk_r && !ls_rd);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sum_r <= 1'b0;
        end else begin
            sum_r <= fifo_enable_bit && ((push_ok && (acc_tag != 3'b000))
                || (sum_r && !(ls_rd && !any_err)));
        end
    end

    // ****************************************************************
    // receive side strobes
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_push_r <= 1'b0;
            rx_hold_off_r <= 1'b0;
            rx_resync_r <= 1'b0;
        end else begin
            // character mode overwrites the holding register on overrun
            rx_push_r <= push_ok || chr_acc;
            rx_hold_off_r <= brk_evt || (rx_hold_off_r && !ser_r);
            rx_resync_r <= rx_char_done && rx_frame_bad;
        end
    end

    // ****************************************************************
    // transmit emptiness
    // ****************************************************************
    logic [4:0] tx_count_r;
    logic txe;
    logic txe_q_r;
    logic tx_idle;
    logic txe_int_r;
    logic tx_grow;

    assign tx_grow = tx_holding_write && (tx_count_r != rx_cap);
    assign txe = (tx_count_r == 5'h00);
    assign tx_idle = txe && !tx_shift_busy;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_count_r <= 5'h00;
            txe_q_r <= 1'b1;
        end else begin
            tx_count_r <= tx_count_r + {4'h0, tx_grow}
                - {4'h0, tx_shift_load && (tx_count_r != 5'h00)};
            txe_q_r <= txe;
        end
    end

    // ****************************************************************
    // interrupt ranking and identity
    // ****************************************************************
    logic line_pend;
    logic rxd_pend;
    logic to_pend;
    logic txe_pend;
    logic modem_pend;
    id_code_type live_code;
    id_code_type shown_code;
    id_code_type frozen_code_r;
    logic frozen_r;
    logic frozen_live;
    logic [7:0] ls_byte;
    logic [7:0] id_byte;

    assign line_pend = en_line
        && (oe_r || par_d || frm_d || brk_d);
    assign rxd_pend = en_rx_data && (fifo_enable_bit ? rx_trigger_reached
        : (rx_count_r != 5'h00));
    assign to_pend = en_rx_data && fifo_enable_bit && rx_timeout;
    assign txe_pend = en_txe && txe_int_r;
    assign modem_pend = en_modem && modem_change;

    always_comb begin
        if (line_pend) begin
            live_code = `ID_LINE;
        end else if (rxd_pend) begin
            live_code = `ID_RXDATA;
        end else if (to_pend) begin
            live_code = `ID_TIMEOUT;
        end else if (txe_pend) begin
            live_code = `ID_TXE;
        end else if (modem_pend) begin
            live_code = `ID_MODEM;
        end else begin
            live_code = `ID_NONE;
        end
    end

    always_comb begin
        unique case (frozen_code_r)
            `ID_LINE: frozen_live = line_pend;
            `ID_RXDATA: frozen_live = rxd_pend;
            `ID_TIMEOUT: frozen_live = to_pend;
            `ID_TXE: frozen_live = txe_pend;
            `ID_MODEM: frozen_live = modem_pend;
            default: frozen_live = 1'b0;
        endcase
    end

    // holds the reported source until its own cause is serviced
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            frozen_r <= 1'b0;
            frozen_code_r <= `ID_NONE;
        end else if (frozen_r) begin
            frozen_r <= frozen_live;
        end else if (id_rd && (live_code != `ID_NONE)) begin
            frozen_r <= 1'b1;
            frozen_code_r <= live_code;
        end
    end

    assign shown_code = frozen_r ? frozen_code_r : live_code;

    // an empty rise re-arms; holding write or reporting it disarms
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txe_int_r <= `TXE_INT_RESET;
        end else begin
            txe_int_r <= (txe && !txe_q_r) || (txe_int_r
                && !tx_holding_write
                && !(id_rd && (shown_code == `ID_TXE)));
        end
    end

    assign ls_byte = {sum_r, tx_idle, txe, brk_d, frm_d, par_d, oe_r,
        rx_count_r != 5'h00};
    assign id_byte = {{2{fifo_enable_bit}}, 2'b00,
        shown_code};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_r <= `RDATA_RESET;
            irq_r <= 1'b0;
        end else begin
            reg_rdata_r <= ls_rd ? ls_byte : (id_rd ? id_byte : 8'h00);
            irq_r <= (live_code != `ID_NONE);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    ready_on_push_a: assert property (
        push_ok |=> (rx_count_r != 5'h00) ##1 1'b1)
        else $error("receive ready not set after push");
    ready_drain_a: assert property (
        (rx_count_r == 5'h01) && pop && !push_ok |=> rx_count_r == 5'h00)
        else $error("receive ready not cleared after drain");
    overrun_read_a: assert property (
        ls_rd && !overrun |=> !oe_r)
        else $error("overrun not cleared by status read");
    overrun_fifo_a: assert property (
        fifo_enable_bit && acc && rx_full |=> oe_r && $stable(wr_ptr_r))
        else $error("fifo overrun wrongly pushed or not shown");
    read_keeps_event_a: assert property (
        ls_rd && chr_acc && acc_tag[`TAG_FRM] |=> frm_r)
        else $error("framing event lost in read cycle");
    break_hold_a: assert property (
        brk_evt |=> (rx_hold_off_r && !push_ok)
            ##1 ($past(ser_r) || (rx_hold_off_r && !push_ok)))
        else $error("break not held off");
    sum_char_mode_a: assert property (
        !fifo_enable_bit |=> !sum_r)
        else $error("bit 7 set in character mode");
    holding_write_a: assert property (
        tx_holding_write && !tx_shift_load |=> !txe)
        else $error("holding empty after write");
    id_fixed_bits_a: assert property (
        id_rd |=> reg_rdata_r[5:4] == 2'b00
            && reg_rdata_r[7:6] == {2{$past(fifo_enable_bit)}})
        else $error("identity fixed bits wrong");
    id_none_bit_a: assert property (
        id_rd |=> reg_rdata_r[0] == ($past(shown_code) == `ID_NONE))
        else $error("identity bit 0 wrong");
    freeze_hold_a: assert property (
        frozen_r && $past(frozen_r) |-> $stable(frozen_code_r))
        else $error("frozen source changed");
    line_first_a: assert property (
        line_pend && !frozen_r |=> irq_r && $past(shown_code) == `ID_LINE)
        else $error("line status not ranked first");

    break_seen_c: cover property (brk_evt ##[1:50] ser_r);
    fifo_overrun_c: cover property (fifo_enable_bit && overrun);
    freeze_c: cover property (id_rd && !frozen_r ##1 frozen_r ##1 !frozen_r);

endmodule : line_status_ident

// ===== logic/line_status_regs.svh
/*
 * Offsets, field positions, reset values and counts of the line status and
 * interrupt identity registers of one serial channel.
 * Assumes an 8-bit register port with a 3-bit word address.
 */
`ifndef LINE_STATUS_REGS_SVH
`define LINE_STATUS_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ID_ADDR 3'h2
`define LS_ADDR 3'h5

// ****************************************************************
// line status fields
// ****************************************************************
`define LS_DR 0
`define LS_OE 1
`define LS_PAR 2
`define LS_FRM 3
`define LS_BRK 4
`define LS_TXE 5
`define LS_IDLE 6
`define LS_SUM 7

// ****************************************************************
// per-character error tag fields
// ****************************************************************
`define TAG_PAR 0
`define TAG_FRM 1
`define TAG_BRK 2

// ****************************************************************
// interrupt identity codes, bits 3..0
// ****************************************************************
`define ID_NONE 4'h1
`define ID_LINE 4'h6
`define ID_RXDATA 4'h4
`define ID_TIMEOUT 4'hc
`define ID_TXE 4'h2
`define ID_MODEM 4'h0

// ****************************************************************
// sizes, counts and reset values
// ****************************************************************
`define RX_DEPTH 5'h10
`define CHAR_DEPTH 5'h01
`define TICKS_PER_BIT_LOG2 4
`define RDATA_RESET 8'h00
`define TXE_INT_RESET 1'b1

`endif

// ===== logic/line_status_pkg.sv
/*
 * Types shared by the line status and interrupt identity logic.
 * Assumes the constants of line_status_regs.svh are included alongside.
 */
package line_status_pkg;

    typedef enum logic [2:0] {
        BRK_IDLE = 3'b001,
        BRK_COUNT = 3'b010,
        BRK_HELD = 3'b100
    } brk_state_type;

    typedef logic [2:0] err_tag_type;
    typedef logic [3:0] id_code_type;

endpackage : line_status_pkg

// ===== tb/host_port_model.sv
/*
 * Host side of the register port: issues one-cycle read or write
 * strobes when the bench asks, and hands back the read data.
 * Assumes bench requests are one-cycle pulses launched on core_clk.
 */
`timescale 1ns/1ps

module host_port_model (
    // clock
    input wire logic core_clk,
    // requests from the bench
    input wire logic rd_go,
    input wire logic wr_go,
    input wire logic [2:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    // register port
    output logic [2:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata_r,
    // read result
    output logic got_valid,
    output logic [7:0] got_data
);
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, got_valid} = '0;
    end

    // released lines toggle so a stale value is never mistaken for data
    always @(posedge core_clk) begin
        reg_rd <= rd_go;
        reg_wr <= wr_go;
        reg_addr <= (rd_go | wr_go) ? cmd_addr : ~reg_addr;
        reg_wdata <= wr_go ? cmd_data : ~reg_wdata;
        got_valid <= reg_rd;
    end

    assign got_data = reg_rdata_r;
endmodule : host_port_model

// ===== tb/uart_line_status_interrupt_id_bench.sv
/*
 * Self-checking bench of the line status and interrupt identity logic.
 * Assumes host_port_model drives the register port; the bench plays
 * the receive and transmit datapaths with one-cycle event pulses.
 */
`timescale 1ns/1ps
`include "line_status_regs.svh"

module uart_line_status_interrupt_id_bench;
    localparam logic [5:0] CHR = 6'h20, PAR = 6'h30, FRM = 6'h28;
    localparam logic [5:0] POP = 6'h04, TWR = 6'h02, TLD = 6'h01;
    logic core_clk, rst_n, reg_wr, reg_rd, fifo_enable_bit, en_rx_data;
    logic en_txe, en_line, en_modem, serial_input, baud16_en;
    logic rx_char_done, rx_parity_bad, rx_frame_bad, rx_data_read;
    logic rx_trigger_reached, rx_timeout, rx_push_r, rx_hold_off_r;
    logic rx_resync_r, tx_holding_write, tx_shift_load, tx_shift_busy;
    logic modem_change, irq_r, rd_go, wr_go, got_valid;
    logic [2:0] reg_addr, cmd_addr;
    logic [3:0] char_bits;
    logic [7:0] reg_wdata, reg_rdata_r, cmd_data, got_data;
    logic [7:0] exp_q[$];
    logic [31:0] lfsr;
    int n_fail, n_compared, n_resync, i;

    line_status_ident i_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_r, .fifo_enable_bit, .en_rx_data,
        .en_txe, .en_line, .en_modem, .serial_input, .baud16_en,
        .char_bits, .rx_char_done, .rx_parity_bad, .rx_frame_bad,
        .rx_data_read, .rx_trigger_reached, .rx_timeout, .rx_push_r,
        .rx_hold_off_r, .rx_resync_r, .tx_holding_write, .tx_shift_load,
        .tx_shift_busy, .modem_change, .irq_r);
    host_port_model i_host (.core_clk, .rd_go, .wr_go, .cmd_addr,
        .cmd_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
        .got_valid, .got_data);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [7:0] idb(input int f, input logic [3:0] c);
        return {f[0], f[0], 2'b00, c};
    endfunction : idb

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk

    task automatic finish_test();
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk);
        rd_go <= 1'b1;
        cmd_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        rd_go <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : rd

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr_go <= 1'b1;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge core_clk);
        wr_go <= 1'b0;
    endtask : wr

    task automatic ev(input logic [5:0] v);
        @(posedge core_clk);
        {rx_char_done, rx_parity_bad, rx_frame_bad, rx_data_read,
         tx_holding_write, tx_shift_load} <= v;
        @(posedge core_clk);
        {rx_char_done, rx_parity_bad, rx_frame_bad, rx_data_read,
         tx_holding_write, tx_shift_load} <= 6'h00;
        repeat (2) @(posedge core_clk);
    endtask : ev

    task automatic flag(input string what, input logic e, input logic g);
        chk(what, {7'h00, e}, {7'h00, g});
    endtask : flag

    // waits at most 200 cycles for a level on rx_push_r or rx_hold_off_r
    task automatic wait_sig(input logic hold, input logic lvl);
        for (i = 0; i < 200; i++) begin
            @(negedge core_clk);
            if ((hold ? rx_hold_off_r : rx_push_r) === lvl)
                break;
        end
        if (i == 200) begin
            n_fail++;
            finish_test();
        end
    endtask : wait_sig

    // ****************************************************************
    // clock and result watcher
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(negedge core_clk) begin
        if (rx_resync_r === 1'b1)
            n_resync++;
        if (got_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unasked read", 8'h00, got_data);
            else
                chk("read data", exp_q.pop_front(), got_data);
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_n, fifo_enable_bit, en_rx_data, en_txe} = '0;
        {en_line, en_modem, baud16_en, rx_char_done, rx_parity_bad} = '0;
        {rx_frame_bad, rx_data_read, rx_trigger_reached, rx_timeout} = '0;
        {tx_holding_write, tx_shift_load, tx_shift_busy} = '0;
        {modem_change, rd_go, wr_go, cmd_addr, cmd_data} = '0;
        serial_input = 1'b1;
        char_bits = 4'ha;
        lfsr = 32'hf888;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`LS_ADDR, 8'h60);
        rd(`ID_ADDR, idb(0, `ID_NONE));
        rd(3'h0, 8'h00);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wr(lfsr[8] ? `LS_ADDR : `ID_ADDR, lfsr[7:0]);
        end
        rd(`LS_ADDR, 8'h60);
        en_modem <= 1'b1;
        modem_change <= 1'b1;
        rd(`ID_ADDR, idb(0, `ID_MODEM));
        {en_modem, modem_change} <= 2'b00;
        en_line <= 1'b1;
        ev(PAR);
        @(negedge core_clk);
        flag("irq", 1'b1, irq_r);
        rd(`ID_ADDR, idb(0, `ID_LINE));
        rd(`LS_ADDR, 8'h65);
        rd(`LS_ADDR, 8'h61);
        ev(CHR);
        rd(`LS_ADDR, 8'h63);
        ev(POP);
        rd(`LS_ADDR, 8'h60);
        en_rx_data <= 1'b1;
        ev(FRM);
        rd(`ID_ADDR, idb(0, `ID_LINE));
        rd(`LS_ADDR, 8'h69);
        rd(`ID_ADDR, idb(0, `ID_RXDATA));
        ev(POP);
        rd(`ID_ADDR, idb(0, `ID_NONE));
        {en_rx_data, en_line} <= 2'b00;
        ev(TWR);
        rd(`LS_ADDR, 8'h00);
        tx_shift_busy <= 1'b1;
        ev(TLD);
        rd(`LS_ADDR, 8'h20);
        en_txe <= 1'b1;
        rd(`ID_ADDR, idb(0, `ID_TXE));
        rd(`ID_ADDR, idb(0, `ID_NONE));
        {en_txe, tx_shift_busy} <= 2'b00;
        // break: shortest character keeps the low stretch at 65 ticks
        char_bits <= 4'h4;
        baud16_en <= 1'b1;
        serial_input <= 1'b0;
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b1, 1'b1);
        flag("irq", 1'b0, irq_r);
        @(posedge core_clk);
        serial_input <= 1'b1;
        wait_sig(1'b1, 1'b0);
        rd(`LS_ADDR, 8'h71);
        rd(`LS_ADDR, 8'h61);
        ev(POP);
        fifo_enable_bit <= 1'b1;
        en_rx_data <= 1'b1;
        rx_timeout <= 1'b1;
        rd(`ID_ADDR, idb(1, `ID_TIMEOUT));
        {rx_timeout, en_rx_data} <= 2'b00;
        ev(CHR);
        ev(PAR);
        rd(`LS_ADDR, 8'he1);
        ev(POP);
        rd(`LS_ADDR, 8'he5);
        ev(POP);
        rd(`LS_ADDR, 8'h60);
        repeat (17) ev(CHR);
        rd(`LS_ADDR, 8'h63);
        repeat (16) ev(POP);
        rd(`LS_ADDR, 8'h60);
        rd(`ID_ADDR, idb(1, `ID_NONE));
        ev(TWR);
        ev(TWR);
        tx_shift_busy <= 1'b1;
        ev(TLD);
        rd(`LS_ADDR, 8'h00);
        chk("resync count", 8'h01, n_resync[7:0]);
        finish_test();
    end
endmodule : uart_line_status_interrupt_id_bench
